// ==== design/rsd_defines.vh ====
// Constants for the run-time settings command decoder.
// Assumes inclusion by bare name from the design folder.
`ifndef RSD_DEFINES_VH
`define RSD_DEFINES_VH

`define RSD_CMD_SET_RUNTIME   8'h60
`define RSD_RESP_SUCCESS      8'h00
`define RSD_IDX_ADC           6'h05
`define RSD_IDX_IRQ           6'h06
`define RSD_IDX_GP_LOAD       6'h07
`define RSD_IDX_GP0           6'h08
`define RSD_IDX_LAST          6'h3F
`define RSD_GP_LOAD_ONE       8'h01

`define RSD_LOAD_BIT          7
`define RSD_ADC_LVL_HI        2
`define RSD_ADC_LVL_LO        1
`define RSD_ADC_SRC_BIT       0
`define RSD_IRQ_RISE_EN_BIT   4
`define RSD_IRQ_RISE_VAL_BIT  3
`define RSD_IRQ_FALL_EN_BIT   2
`define RSD_IRQ_FALL_VAL_BIT  1
`define RSD_IRQ_CLR_BIT       0
`define RSD_GP_VAL_BIT        4
`define RSD_GP_DIR_BIT        3
`define RSD_GP_FUNC_HI        2

`define RSD_FUNC_GPIO         3'h0
`define RSD_FUNC_SUSPEND      3'h1
`define RSD_FUNC_UART_LED     3'h2

`define RSD_RST_ADC_LVL       2'h0
`define RSD_RST_ADC_SRC       1'h0
`define RSD_RST_EDGE_EN       1'h0
`define RSD_RST_GP_FUNC       3'h0
`define RSD_RST_GP_DIR        1'h1
`define RSD_RST_GP_VAL        1'h0

`define RSD_ADDR_STATUS       8'h00
`define RSD_ADDR_MASK         8'h04
`define RSD_ADDR_SETTINGS     8'h08

`define RSD_EV_APPLIED        0
`define RSD_EV_EDGE           1
`define RSD_EV_IGNORED        2
`define RSD_EV_W              3

`endif

// ==== design/rsd_runtime_settings_decoder.v ====
// Run-time settings command decoder: takes a 64-byte command report one
// byte at a time, applies the reference, edge-detector and pin 0 fields,
// and raises a two-byte answer. Registers sit on classic Wishbone.
// Assumes report bytes and pin inputs are synchronous to clk_in.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rsd_defines.vh"

// Behaviour
// - Updates live only in volatile flops.
// - Byte5 bit7 gates reference selection load.
// - Byte5 bits2-1 pick reference module level.
// - Byte5 bit0 picks internal module or supply.
// - Byte6 bit7 gates all detector changes.
// - Byte6 bit4 loads rising enable from bit3.
// - Byte6 bit2 loads falling enable from bit1.
// - Byte6 bit0 one clears detection flag.
// - Byte7 one loads pin settings from byte8.
// - Output mode drives pin from byte8 bit4.
// - Byte8 bit3 direction, only in GPIO mode.
// - Byte8 bits2-0 choose pin zero function.
// - Answer echoes code and success byte.
module rsd_runtime_settings_decoder (
	input  wire        clk_in,
	input  wire        reset_in,
	input  wire        rpt_valid_in,
	input  wire        rpt_first_in,
	input  wire [7:0]  rpt_data_in,
	output wire        rpt_ready_out,
	output wire        resp_valid_out,
	output reg  [7:0]  resp_code_out,
	output reg  [7:0]  resp_status_out,
	input  wire        resp_ready_in,
	input  wire        edge_pin_in,
	input  wire        suspend_in,
	input  wire        uart_rx_activity_in,
	input  wire        general_pin_zero_in,
	output reg         general_pin_zero_out,
	output reg         general_pin_zero_oe_out,
	output reg  [1:0]  adc_ref_level_out,
	output reg         adc_ref_internal_out,
	output reg         edge_flag_out,
	output wire        irq_out,
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [7:0]  wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out
);

	// All state below is volatile: reset, and only reset, brings back
	// the power-up defaults, and nothing here stores them anywhere.
	reg        started_q;
	reg [5:0]  cnt_q;
	reg [7:0]  cmd_q;
	reg [7:0]  adc_byte_q;
	reg [7:0]  irq_byte_q;
	reg [7:0]  gp_load_q;
	reg [7:0]  gp_byte_q;
	reg        resp_q;

	// Volatile settings and pin state.
	reg        rise_en_q;
	reg        fall_en_q;
	reg        edge_prev_q;
	reg [2:0]  gp_func_q;
	reg        gp_dir_q;
	reg        gp_val_q;

	// Sticky events and their mask.
	reg [`RSD_EV_W-1:0] status_q;
	reg [`RSD_EV_W-1:0] mask_q;

	// A report byte is taken on any rising edge with valid and ready both high;
	// a first byte restarts the index whatever the count says.
	wire       byte_take = rpt_valid_in & rpt_ready_out;
	wire [5:0] idx = rpt_first_in ? 6'h00 : cnt_q;
	wire       pkt_end = byte_take & (rpt_first_in | started_q) &
	                     (idx == `RSD_IDX_LAST);
	wire       cmd_ok = (cmd_q == `RSD_CMD_SET_RUNTIME);
	wire       apply = pkt_end & cmd_ok;
	wire       ignore = pkt_end & ~cmd_ok;
	wire       irq_load = apply & irq_byte_q[`RSD_LOAD_BIT];
	wire       rise_hit = rise_en_q & edge_pin_in & ~edge_prev_q;
	wire       fall_hit = fall_en_q & ~edge_pin_in & edge_prev_q;
	wire       edge_hit = rise_hit | fall_hit;
	wire       flag_clr = irq_load & irq_byte_q[`RSD_IRQ_CLR_BIT];
	// The ack itself blocks a second take of the same request, so the
	// master may hold cyc and stb through the acknowledge edge.
	wire       wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire       wb_wr = wb_req & wb_we_in & wb_sel_in[0];
	wire       status_rd = wb_req & ~wb_we_in &
	                       (wb_adr_in == `RSD_ADDR_STATUS);
	wire [`RSD_EV_W-1:0] ev_set;
	wire [31:0] settings_word;

	// Field views of the captured bytes; the don't-care bits of bytes
	// 5, 6 and 8 are simply never looked at.
	wire       adc_load      = adc_byte_q[`RSD_LOAD_BIT];
	wire [1:0] adc_level_new = adc_byte_q[`RSD_ADC_LVL_HI:`RSD_ADC_LVL_LO];
	wire       adc_src_new   = adc_byte_q[`RSD_ADC_SRC_BIT];
	wire       rise_load     = irq_byte_q[`RSD_IRQ_RISE_EN_BIT];
	wire       rise_val_new  = irq_byte_q[`RSD_IRQ_RISE_VAL_BIT];
	wire       fall_load     = irq_byte_q[`RSD_IRQ_FALL_EN_BIT];
	wire       fall_val_new  = irq_byte_q[`RSD_IRQ_FALL_VAL_BIT];
	wire       gp_load       = (gp_load_q == `RSD_GP_LOAD_ONE);
	wire [2:0] gp_func_new   = gp_byte_q[`RSD_GP_FUNC_HI:0];
	wire       gp_dir_new    = gp_byte_q[`RSD_GP_DIR_BIT];
	wire       gp_val_new    = gp_byte_q[`RSD_GP_VAL_BIT];
	wire       mask_wr       = wb_wr & (wb_adr_in == `RSD_ADDR_MASK);

	// A new report is refused while the previous answer waits, so the
	// host never loses an answer but must drain it first.
	assign rpt_ready_out  = ~resp_q;
	assign resp_valid_out = resp_q;
	assign irq_out        = |(status_q & mask_q);

	assign ev_set[`RSD_EV_APPLIED] = apply;
	assign ev_set[`RSD_EV_EDGE]    = edge_hit;
	assign ev_set[`RSD_EV_IGNORED] = ignore;

	// Settings read-back word; unused bits read as zero.
	assign settings_word[31:14] = 18'h00000;
	assign settings_word[13]    = general_pin_zero_in;
	assign settings_word[12]    = gp_val_q;
	assign settings_word[11]    = gp_dir_q;
	assign settings_word[10:8]  = gp_func_q;
	assign settings_word[7]     = 1'b0;
	assign settings_word[6]     = edge_flag_out;
	assign settings_word[5]     = fall_en_q;
	assign settings_word[4]     = rise_en_q;
	assign settings_word[3]     = 1'b0;
	assign settings_word[2:1]   = adc_ref_level_out;
	assign settings_word[0]     = adc_ref_internal_out;

	// Byte capture. Only the command byte and bytes 5 to 8 are kept; the
	// rest of the report is counted and dropped.
	always @(posedge clk_in) begin
		if (reset_in) begin
			started_q  <= 1'b0;
			cnt_q      <= 6'h00;
			cmd_q      <= 8'h00;
			adc_byte_q <= 8'h00;
			irq_byte_q <= 8'h00;
			gp_load_q  <= 8'h00;
		end else if (byte_take) begin
			cnt_q <= idx + 6'h01;
			if (rpt_first_in) begin
				started_q <= 1'b1;
				cmd_q     <= rpt_data_in;
			end else if (pkt_end) begin
				started_q <= 1'b0;
			end
			if (idx == `RSD_IDX_ADC)
				adc_byte_q <= rpt_data_in;
			if (idx == `RSD_IDX_IRQ)
				irq_byte_q <= rpt_data_in;
			if (idx == `RSD_IDX_GP_LOAD)
				gp_load_q <= rpt_data_in;
		end
	end

	// Settings apply when the last byte arrives, pin 0 included; byte 8
	// is only staged here, at that byte.
	always @(posedge clk_in) begin
		if (reset_in) begin
			gp_byte_q <= 8'h00;
		end else if (byte_take & (idx == `RSD_IDX_GP0)) begin
			gp_byte_q <= rpt_data_in;
		end
	end

	// Reference selection; reset puts back the power-up default.
	always @(posedge clk_in) begin
		if (reset_in) begin
			adc_ref_level_out    <= `RSD_RST_ADC_LVL;
			adc_ref_internal_out <= `RSD_RST_ADC_SRC;
		end else if (apply & adc_load) begin
			adc_ref_level_out    <= adc_level_new;
			adc_ref_internal_out <= adc_src_new;
		end
	end

	// Edge detector enables; each direction has its own load bit.
	always @(posedge clk_in) begin
		if (reset_in) begin
			rise_en_q <= `RSD_RST_EDGE_EN;
			fall_en_q <= `RSD_RST_EDGE_EN;
		end else if (irq_load) begin
			if (rise_load)
				rise_en_q <= rise_val_new;
			if (fall_load)
				fall_en_q <= fall_val_new;
		end
	end

	// Pin 0 settings. Byte 7 counts as set only when it holds exactly
	// one; any other value keeps the current designation.
	always @(posedge clk_in) begin
		if (reset_in) begin
			gp_func_q <= `RSD_RST_GP_FUNC;
			gp_dir_q  <= `RSD_RST_GP_DIR;
			gp_val_q  <= `RSD_RST_GP_VAL;
		end else if (apply & gp_load) begin
			gp_func_q <= gp_func_new;
			gp_dir_q  <= gp_dir_new;
			gp_val_q  <= gp_val_new;
		end
	end

	// Previous pin sample for edge detection.
	always @(posedge clk_in) begin
		if (reset_in) begin
			edge_prev_q <= 1'b0;
		end else begin
			edge_prev_q <= edge_pin_in;
		end
	end

	// Detection flag; a new edge wins over a clear in the same cycle,
	// so an edge that lands in the cycle the clearing command applies is not lost.
	always @(posedge clk_in) begin
		if (reset_in) begin
			edge_flag_out <= 1'b0;
		end else if (edge_hit) begin
			edge_flag_out <= 1'b1;
		end else if (flag_clr) begin
			edge_flag_out <= 1'b0;
		end
	end

	// Pin 0 next drive. Direction only matters in GPIO mode; undefined
	// function codes leave the pin undriven.
	reg        pin_d;
	reg        pin_oe_d;
	always @* begin
		pin_d    = 1'b0;
		pin_oe_d = 1'b0;
		case (gp_func_q)
		`RSD_FUNC_GPIO: begin
			pin_d    = gp_val_q;
			pin_oe_d = ~gp_dir_q;
		end
		`RSD_FUNC_SUSPEND: begin
			pin_d    = suspend_in;
			pin_oe_d = 1'b1;
		end
		`RSD_FUNC_UART_LED: begin
			pin_d    = uart_rx_activity_in;
			pin_oe_d = 1'b1;
		end
		default: begin
			pin_d    = 1'b0;
			pin_oe_d = 1'b0;
		end
		endcase
	end

	// Pin 0 drive registers; the pin follows its settings a cycle later.
	always @(posedge clk_in) begin
		if (reset_in) begin
			general_pin_zero_out    <= 1'b0;
			general_pin_zero_oe_out <= 1'b0;
		end else begin
			general_pin_zero_out    <= pin_d;
			general_pin_zero_oe_out <= pin_oe_d;
		end
	end

	// Answer pending flag, held until the host takes it.
	always @(posedge clk_in) begin
		if (reset_in) begin
			resp_q <= 1'b0;
		end else if (apply) begin
			resp_q <= 1'b1;
		end else if (resp_q & resp_ready_in) begin
			resp_q <= 1'b0;
		end
	end

	// Answer bytes. They are rewritten only by an applied command, so
	// they stand unchanged for as long as the answer waits.
	always @(posedge clk_in) begin
		if (reset_in) begin
			resp_code_out   <= 8'h00;
			resp_status_out <= 8'h00;
		end else if (apply) begin
			resp_code_out   <= `RSD_CMD_SET_RUNTIME;
			resp_status_out <= `RSD_RESP_SUCCESS;
		end
	end

	// Sticky events cleared by a status read; a set in the read cycle
	// survives the clear.
	always @(posedge clk_in) begin
		if (reset_in) begin
			status_q <= {`RSD_EV_W{1'b0}};
		end else begin
			status_q <= (status_rd ? {`RSD_EV_W{1'b0}} : status_q) | ev_set;
		end
	end

	// Interrupt mask; a write needs byte lane 0 enabled.
	always @(posedge clk_in) begin
		if (reset_in) begin
			mask_q <= {`RSD_EV_W{1'b0}};
		end else if (mask_wr) begin
			mask_q <= wb_dat_in[`RSD_EV_W-1:0];
		end
	end

	// Wishbone acknowledge: one wait cycle for every request, mapped or
	// not, so a stray address never hangs the master.
	always @(posedge clk_in) begin
		if (reset_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= wb_req;
		end
	end

	// Read data, captured with the request; unmapped reads give zero.
	always @(posedge clk_in) begin
		if (reset_in) begin
			wb_dat_out <= 32'h00000000;
		end else begin
			if (wb_req & ~wb_we_in) begin
				case (wb_adr_in)
				`RSD_ADDR_STATUS:
					wb_dat_out <= {29'h00000000, status_q};
				`RSD_ADDR_MASK:
					wb_dat_out <= {29'h00000000, mask_q};
				`RSD_ADDR_SETTINGS:
					wb_dat_out <= settings_word;
				default:
					wb_dat_out <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // rsd_runtime_settings_decoder

// ==== dv/rsd_checker_sva.sv ====
// Checker for the settings decoder, seeing only the decoder's ports.
// Assumes one clock with a synchronous active-high reset; bound from the tb.
`timescale 1ns/1ps
module rsd_checker (
	input wire       clk_in,
	input wire       reset_in,
	input wire       rpt_ready_out,
	input wire       resp_valid_out,
	input wire       resp_ready_in,
	input wire [7:0] resp_code_out,
	input wire [7:0] resp_status_out,
	input wire [1:0] adc_ref_level_out,
	input wire       adc_ref_internal_out,
	input wire       edge_flag_out,
	input wire       wb_cyc_in,
	input wire       wb_stb_in,
	input wire       wb_ack_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_answer_fields: assert property (resp_valid_out |->
		resp_code_out == 8'h60 && resp_status_out == 8'h00) else $error("reply");
	a_answer_held: assert property (resp_valid_out && !resp_ready_in
		|=> resp_valid_out) else $error("reply dropped");
	a_answer_taken: assert property (resp_valid_out && resp_ready_in
		|-> ##1 !resp_valid_out) else $error("reply kept");
	a_link_blocked: assert property (rpt_ready_out == !resp_valid_out)
		else $error("ready wrong");
	a_level_gated: assert property (!$stable(adc_ref_level_out)
		|-> $rose(resp_valid_out)) else $error("level moved");
	a_source_gated: assert property (!$stable(adc_ref_internal_out)
		|-> $rose(resp_valid_out)) else $error("source moved");
	a_flag_clear_gated: assert property ($fell(edge_flag_out)
		|-> $rose(resp_valid_out)) else $error("flag cleared");
	a_ack_prompt: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
		|=> wb_ack_out ##1 !wb_ack_out) else $error("ack timing");
endmodule // rsd_checker

// ==== dv/rsd_host_model.sv ====
// Host model: sends 64-byte command reports, one byte per accepted cycle.
// Assumes the testbench calls send and takes the answer itself.
`timescale 1ns/1ps
module rsd_host_model (
	input  wire       clk_in,
	input  wire       ready_in,
	output reg        valid_out,
	output reg        first_out,
	output reg  [7:0] data_out
);
	integer i, j;
	reg     stuck;
	initial {valid_out, first_out, data_out} = 10'h000;
	initial stuck = 1'b0;
	// Idle data toggles, so a stale byte can never pass for a fresh one.
	task send(input [7:0] b0, b5, b6, b7, b8, input slow);
		for (i = 0; i < 64; i = i + 1) begin
			if (slow && i[0]) begin
				valid_out <= 1'b0;
				data_out <= ~data_out;
				@(posedge clk_in);
			end
			valid_out <= 1'b1;
			first_out <= (i == 0);
			data_out <= i == 0 ? b0 : i == 5 ? b5 : i == 6 ? b6 :
				i == 7 ? b7 : i == 8 ? b8 : 8'hA5 ^ i[7:0];
			j = 0;
			do begin
				@(posedge clk_in);
				j = j + 1;
			end while (ready_in !== 1'b1 && j < 70);
			if (ready_in !== 1'b1)
				stuck = 1'b1;
		end
		{valid_out, first_out} <= 2'h0;
		data_out <= ~data_out;
	endtask
endmodule // rsd_host_model

// ==== dv/tb_runtime_settings_cmd_decoder.sv ====
// Testbench: random and corner reports, register and pin checks.
// Assumes the decoder, host model and checker are compiled before it.
`timescale 1ns/1ps
module tb_runtime_settings_cmd_decoder;
	reg         clk_in, reset_in, resp_ready_in, edge_pin_in, suspend_in, o;
	reg         uart_rx_activity_in, general_pin_zero_in, wb_cyc_in, wb_we_in;
	reg  [7:0]  wb_adr_in, b5, b6, b8;
	reg  [31:0] wb_dat_in, rd, exp_set;
	reg  [2:0]  f;
	wire        rpt_valid_in, rpt_first_in, rpt_ready_out, resp_valid_out;
	wire        general_pin_zero_out, general_pin_zero_oe_out, wb_ack_out;
	wire        adc_ref_internal_out, edge_flag_out, irq_out;
	wire [7:0]  rpt_data_in, resp_code_out, resp_status_out;
	wire [1:0]  adc_ref_level_out;
	wire [31:0] wb_dat_out;
	integer     fails, comparisons, seed, n, k, m;
	rsd_host_model u_host (.clk_in(clk_in), .ready_in(rpt_ready_out),
		.valid_out(rpt_valid_in), .first_out(rpt_first_in),
		.data_out(rpt_data_in));
	rsd_runtime_settings_decoder u_dut (.*, .wb_stb_in(wb_cyc_in),
		.wb_sel_in(4'hF));
	function [31:0] upd(input [31:0] s, input [7:0] c5, c6, c7, c8);
		upd = s;
		if (c5[7]) upd[2:0] = c5[2:0];
		if (c6[7] && c6[4]) upd[4] = c6[3];
		if (c6[7] && c6[2]) upd[5] = c6[1];
		if (c6[7] && c6[0]) upd[6] = 1'b0;
		if (c7 == 8'h01) upd[12:8] = c8[4:0];
	endfunction
	task check(input [31:0] e, s, input [63:0] nm);
		comparisons = comparisons + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("Error %0s expected %h seen %h", nm, e, s);
		end
	endtask
	task report_and_stop;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wb(input w, input [7:0] a, input [31:0] d);
		{wb_cyc_in, wb_we_in, wb_adr_in, wb_dat_in} <= {1'b1, w, a, d};
		n = 0;
		do begin
			@(posedge clk_in);
			n = n + 1;
		end while (wb_ack_out !== 1'b1 && n < 20);
		rd = wb_dat_out;
		if (wb_ack_out !== 1'b1) begin
			fails = fails + 1;
			report_and_stop;
		end
		wb_cyc_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task verify;
		wb(0, 8'h08, 0);
		exp_set[13] = general_pin_zero_in;
		f = exp_set[10:8];
		o = f < 3 && !(f == 0 && exp_set[11]);
		check(exp_set, rd, "settings");
		check(exp_set[2:0], {adc_ref_level_out, adc_ref_internal_out}, "adc");
		check(o, general_pin_zero_oe_out, "oe");
		if (o) check(f == 0 ? exp_set[12] : f[0] ? suspend_in :
			uart_rx_activity_in, general_pin_zero_out, "pin");
	endtask
	task cmd(input [7:0] b0, c5, c6, c7, c8, input slow);
		u_host.send(b0, c5, c6, c7, c8, slow);
		check(0, u_host.stuck, "link");
		if (u_host.stuck) report_and_stop;
		for (k = 0; k < 8 && resp_valid_out !== 1'b1; k = k + 1)
			@(posedge clk_in);
		check(b0 == 8'h60, resp_valid_out, "answer");
		if (b0 == 8'h60 && resp_valid_out !== 1'b1) report_and_stop;
		if (b0 == 8'h60) exp_set = upd(exp_set, c5, c6, c7, c8);
		resp_ready_in <= 1'b1;
		@(posedge clk_in);
		resp_ready_in <= 1'b0;
		verify;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		repeat (100000) @(posedge clk_in);
		fails = fails + 1;
		report_and_stop;
	end
	initial begin
		{reset_in, resp_ready_in, edge_pin_in, suspend_in} = 4'h8;
		{uart_rx_activity_in, general_pin_zero_in, wb_cyc_in, wb_we_in} = 4'h0;
		{wb_adr_in, wb_dat_in, fails, comparisons, seed} = {40'h0, 64'h0, 32'h8};
		exp_set = 32'h0800;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		verify;
		wb(1, 8'h04, 32'h7);
		wb(0, 8'h10, 0);
		check(0, rd, "unmapped");
		for (m = 0; m < 20; m = m + 1) begin
			{b5, b6, b8} = 24'($random(seed));
			{suspend_in, uart_rx_activity_in, general_pin_zero_in} <= 3'($random(seed));
			if (m < 8) b8[3:0] = {1'b0, m[2:0]};
			cmd(8'h60, b5, b6, m < 8 ? 8'h01 : {6'h00, m[1:0]}, b8, m[0]);
		end
		check(1, irq_out, "irq");
		wb(0, 8'h00, 0);
		check(32'h1, rd, "status");
		check(0, irq_out, "irqclr");
		cmd(8'h61, 8'h87, 8'h81, 8'h01, 8'h12, 0);
		wb(1, 8'h04, 0);
		cmd(8'h60, 0, 8'h9C, 0, 0, 0);
		edge_pin_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		exp_set[6] = 1'b1;
		check(0, irq_out, "masked");
		wb(0, 8'h00, 0);
		check(32'h7, rd, "status");
		edge_pin_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		wb(0, 8'h00, 0);
		check(0, rd, "nofall");
		cmd(8'h60, 0, 8'h01, 0, 0, 1);
		cmd(8'h60, 0, 8'h81, 0, 0, 1);
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		exp_set = 32'h0800;
		@(posedge clk_in);
		verify;
		check(0, irq_out, "irqrst");
		report_and_stop;
	end
endmodule // tb_runtime_settings_cmd_decoder
bind rsd_runtime_settings_decoder rsd_checker u_chk (.*);
